/* design/cmbc_comm_config.sv */
// Comm config block top: protocol and baud selection, two-word energy
// reads, data scalar and communication LEDs.
// Assumes the protocol engine decodes host accesses onto the register
// port, and that energy and connection events come on clk_sys.
`timescale 1ns/1ps
`include "cmbc_map.svh"

module cmbc_comm_config
	import cmbc_pkg::*;
#(
	parameter logic [31:0] EDIT_CYCLES = 32'(`CMBC_EDIT_CYCLES),
	parameter logic [31:0] FLASH_CYCLES = 32'(`CMBC_FLASH_CYCLES)
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [3:0] swHighPin,
	input wire logic [3:0] swMidPin,
	input wire logic [3:0] swLowPin,
	input wire logic [15:0] regAddr,
	input wire logic [15:0] regWrData,
	input wire logic regWrEn,
	input wire logic regRdEn,
	output logic [15:0] regRdData,
	output logic regRdValid,
	input wire logic [31:0] energyTotal,
	input wire logic hostConnecting,
	input wire logic hostFailed,
	output logic bacnetMode,
	output cmbc_baud_t baudCode,
	output logic [3:0] dataBits,
	output logic parityEnable,
	output logic [1:0] stopBits,
	output logic [2:0] scalarCode,
	output logic [11:0] switchAddr,
	output logic addrValid,
	output logic serialLedRed,
	output logic commLedRed,
	output logic commLedGreen,
	output logic [2:0] phaseLedGreen
);

	// --------------------------------------------------------------
	// Switch recovery
	// --------------------------------------------------------------
	logic recActive; // Edit window open
	logic recApply; // One-cycle: selections take effect
	logic recProtoOk;
	logic recBacnet;
	logic recBaudOk;
	cmbc_baud_t recBaud;
	logic failsafe; // All switches zero
	logic [11:0] swValue; // Synchronised switch digits
	logic bacnet_q, bacnet_d; // Stored protocol, 1 = BACnet

	cmbc_switch_recovery #(
		.EDIT_CYCLES(EDIT_CYCLES)
	) u_recovery (
		.clk_sys(clk_sys),
		.rst(rst),
		.swHighPin(swHighPin),
		.swMidPin(swMidPin),
		.swLowPin(swLowPin),
		.curBacnet(bacnet_q),
		.recoveryActive(recActive),
		.applyPulse(recApply),
		.protoOk(recProtoOk),
		.newBacnet(recBacnet),
		.baudOk(recBaudOk),
		.newBaud(recBaud),
		.failsafe(failsafe),
		.switchAddr(swValue)
	);

	// --------------------------------------------------------------
	// Configuration registers
	// --------------------------------------------------------------
	cmbc_baud_t baud_q, baud_d; // Stored baud code
	logic [2:0] scalar_q, scalar_d; // Stored data scalar, saturated
	logic [15:0] snapHigh_q, snapHigh_d; // Upper word held at low read
	logic [15:0] rdData_q, rdData_d;
	logic rdValid_q, rdValid_d;

	// Write, read and recovery effects
	always_comb begin
		bacnet_d = bacnet_q;
		baud_d = baud_q;
		scalar_d = scalar_q;
		snapHigh_d = snapHigh_q;
		rdData_d = rdData_q;
		rdValid_d = regRdEn;
		if (regWrEn) begin
			// Protocol key only honoured in the mode it belongs to
			if (!bacnet_q && regAddr == `CMBC_REG_PROTO &&
				regWrData == `CMBC_KEY_TO_BACNET) begin
				bacnet_d = 1'b1;
				baud_d = `CMBC_BAUD_76800;
			end else if (bacnet_q && regAddr == `CMBC_OBJ_PROTO &&
				regWrData == `CMBC_KEY_TO_MODBUS) begin
				bacnet_d = 1'b0;
				baud_d = `CMBC_BAUD_9600;
			end else if (regAddr == `CMBC_REG_BAUD &&
				baudOk16(regWrData, bacnet_q)) begin
				baud_d = regWrData[2:0];
			end else if (regAddr == `CMBC_REG_SCALAR) begin
				scalar_d = satScalar(regWrData);
			end
		end
		// Recovery lands after the window; it overrides a same-cycle bus write for the settings it selects
		if (recApply) begin
			if (recProtoOk) begin
				bacnet_d = recBacnet;
			end
			if (recBaudOk) begin
				baud_d = recBaud;
			end else if (recProtoOk && recBacnet &&
				!baudOk16({13'h0000, baud_q}, 1'b1)) begin
				// Kept baud would be illegal under BACnet: use default
				baud_d = `CMBC_BAUD_76800;
			end
		end
		if (regRdEn) begin
			case (regAddr)
				`CMBC_REG_ENERGY_LO: begin
					rdData_d = energyTotal[15:0];
					snapHigh_d = energyTotal[31:16];
				end
				`CMBC_REG_ENERGY_HI: rdData_d = snapHigh_q;
				`CMBC_REG_SCALAR: rdData_d = {13'h0000, scalar_q};
				`CMBC_REG_PROTO: rdData_d = {15'h0000, bacnet_q};
				`CMBC_OBJ_PROTO: rdData_d = {15'h0000, bacnet_q};
				`CMBC_REG_BAUD: rdData_d = {13'h0000, baud_q};
				default: rdData_d = 16'h0000; // Unmapped reads zero
			endcase
		end
	end

	// Register the configuration
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			bacnet_q <= 1'b0;
			baud_q <= `CMBC_BAUD_9600;
			scalar_q <= 3'h0;
			snapHigh_q <= 16'h0000;
			rdData_q <= 16'h0000;
			rdValid_q <= 1'b0;
		end else begin
			bacnet_q <= bacnet_d;
			baud_q <= baud_d;
			scalar_q <= scalar_d;
			snapHigh_q <= snapHigh_d;
			rdData_q <= rdData_d;
			rdValid_q <= rdValid_d;
		end
	end

	// Saturate a written scalar at its top setting
	function automatic logic [2:0] satScalar(input logic [15:0] v);
		logic [2:0] s;
		s = `CMBC_SCALAR_MAX;
		if (v < 16'(`CMBC_SCALAR_MAX)) begin
			s = v[2:0];
		end
		return s;
	endfunction : satScalar

	// Baud code legal for the protocol in force
	function automatic logic baudOk16(input logic [15:0] v,
		input logic bac);
		logic ok;
		ok = (v >= 16'(`CMBC_BAUD_9600)) && (v <= 16'(`CMBC_BAUD_115200));
		if (bac && (v == 16'(`CMBC_BAUD_57600) ||
			v == 16'(`CMBC_BAUD_115200))) begin
			ok = 1'b0;
		end
		return ok;
	endfunction : baudOk16

	// --------------------------------------------------------------
	// Communication status LED
	// --------------------------------------------------------------
	cmbc_led_e led_q, led_d;
	logic [31:0] ledCnt_q, ledCnt_d; // Time spent flashing

	// Flash sequence after connect attempts
	always_comb begin
		led_d = led_q;
		ledCnt_d = ledCnt_q + 32'h0000_0001;
		case (led_q)
			LED_SOLID: begin
				ledCnt_d = 32'h0000_0000;
				if (hostFailed) begin
					led_d = LED_FAIL;
				end else if (hostConnecting) begin
					led_d = LED_CONN;
				end
			end
			LED_CONN, LED_FAIL: begin
				// Failure overrides a connect flash in progress
				if (hostFailed && led_q == LED_CONN) begin
					led_d = LED_FAIL;
					ledCnt_d = 32'h0000_0000;
				end else if (ledCnt_q >= FLASH_CYCLES - 32'h0000_0001) begin
					led_d = LED_SOLID;
				end
			end
			default: begin
				led_d = LED_SOLID;
			end
		endcase
	end

	// Register the LED sequence
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			led_q <= LED_SOLID;
			ledCnt_q <= 32'h0000_0000;
		end else begin
			led_q <= led_d;
			ledCnt_q <= ledCnt_d;
		end
	end

	// --------------------------------------------------------------
	// Outputs
	// --------------------------------------------------------------
	logic blink; // Flash phase
	assign blink = ledCnt_q[`CMBC_BLINK_BIT];

	// Failsafe overrides stored settings without touching them
	assign bacnetMode = failsafe ? 1'b0 : bacnet_q;
	assign baudCode = failsafe ? `CMBC_BAUD_9600 : baud_q;
	assign dataBits = `CMBC_DATA_BITS;
	assign parityEnable = 1'b0;
	assign stopBits = `CMBC_STOP_BITS;
	assign scalarCode = scalar_q;
	assign regRdData = rdData_q;
	assign regRdValid = rdValid_q;
	assign switchAddr = swValue;
	assign addrValid = !recActive;

	// Recovery display takes priority over normal status
	always_comb begin
		serialLedRed = 1'b0;
		commLedRed = 1'b0;
		commLedGreen = 1'b1;
		phaseLedGreen = 3'h0;
		if (recActive) begin
			commLedGreen = 1'b0;
			if (swValue[3:0] == `CMBC_DIGIT_MODBUS) begin
				serialLedRed = 1'b1;
			end else if (swValue[3:0] == `CMBC_DIGIT_BACNET) begin
				serialLedRed = 1'b1;
				commLedRed = 1'b1;
			end
			if (swValue[11:8] >= 4'(`CMBC_BAUD_9600) &&
				swValue[11:8] <= 4'(`CMBC_BAUD_115200)) begin
				phaseLedGreen = swValue[10:8];
			end
		end else if (led_q == LED_CONN) begin
			commLedGreen = blink;
		end else if (led_q == LED_FAIL) begin
			commLedGreen = 1'b0;
			// Red phase starts lit so a failure shows at once
			commLedRed = !blink;
		end
	end

endmodule : cmbc_comm_config

/* design/cmbc_map.svh */
// Register numbers, key values, codes and times of the comm config block.
// Assumes a 50 MHz system clock; included by bare name.
`ifndef CMBC_MAP_SVH
`define CMBC_MAP_SVH

// ----------------------------------------------------------------------
// Register numbers as seen on the register port
// ----------------------------------------------------------------------
`define CMBC_REG_ENERGY_LO 16'hABE1
`define CMBC_REG_ENERGY_HI 16'hABE2
`define CMBC_REG_SCALAR 16'hAE3A
`define CMBC_REG_PROTO 16'hAE44
`define CMBC_REG_BAUD 16'hAE45
`define CMBC_OBJ_PROTO 16'h27CE

// ----------------------------------------------------------------------
// Key values and codes
// ----------------------------------------------------------------------
`define CMBC_KEY_TO_BACNET 16'h0729
`define CMBC_KEY_TO_MODBUS 16'h0177
`define CMBC_BAUD_9600 3'h1
`define CMBC_BAUD_19200 3'h2
`define CMBC_BAUD_38400 3'h3
`define CMBC_BAUD_57600 3'h4
`define CMBC_BAUD_76800 3'h5
`define CMBC_BAUD_115200 3'h6
`define CMBC_SCALAR_MAX 3'h6
`define CMBC_DATA_BITS 4'h8
`define CMBC_STOP_BITS 2'h1
`define CMBC_DIGIT_RECOVER 4'h9
`define CMBC_DIGIT_MODBUS 4'h1
`define CMBC_DIGIT_BACNET 4'h2

// ----------------------------------------------------------------------
// Times
// ----------------------------------------------------------------------
`define CMBC_CLK_HZ 50000000
`define CMBC_EDIT_WINDOW_MS 10000
`define CMBC_EDIT_CYCLES ((`CMBC_CLK_HZ / 1000) * `CMBC_EDIT_WINDOW_MS)
`define CMBC_FLASH_MS 1000
`define CMBC_FLASH_CYCLES ((`CMBC_CLK_HZ / 1000) * `CMBC_FLASH_MS)
`define CMBC_BLINK_BIT 22
`define CMBC_SETTLE_CYCLES 2'h3

`endif

/* design/cmbc_pkg.sv */
// Types shared by the comm config block files.
// Constants live in cmbc_map.svh; this holds types only.
package cmbc_pkg;

	// Switch recovery sequencer states
	typedef enum logic [1:0] {RC_BOOT, RC_EDIT, RC_DONE} cmbc_rec_e;

	// Communication status LED states
	typedef enum logic [1:0] {LED_SOLID, LED_CONN, LED_FAIL} cmbc_led_e;

	// Baud code, 1..6 from 9600 up to 115200
	typedef logic [2:0] cmbc_baud_t;

endpackage : cmbc_pkg

/* design/cmbc_switch_recovery.sv */
// Rotary address switch handling: power-up recovery window and failsafe.
// Assumes switch pins are asynchronous BCD digits; rst held at power-up.
`timescale 1ns/1ps
`include "cmbc_map.svh"

module cmbc_switch_recovery
	import cmbc_pkg::*;
#(
	parameter logic [31:0] EDIT_CYCLES = 32'(`CMBC_EDIT_CYCLES)
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [3:0] swHighPin,
	input wire logic [3:0] swMidPin,
	input wire logic [3:0] swLowPin,
	input wire logic curBacnet,
	output logic recoveryActive,
	output logic applyPulse,
	output logic protoOk,
	output logic newBacnet,
	output logic baudOk,
	output cmbc_baud_t newBaud,
	output logic failsafe,
	output logic [11:0] switchAddr
);

	// --------------------------------------------------------------
	// Two-stage synchroniser
	// --------------------------------------------------------------
	logic [11:0] swMeta_q; // First stage, read only by second
	logic [11:0] swSync_q; // Safe switch value
	logic [11:0] swPrev_q; // Previous safe value, for change detect

	// Pins are asynchronous, so only the second stage looks at the first
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			swMeta_q <= 12'h000;
			swSync_q <= 12'h000;
			swPrev_q <= 12'h000;
		end else begin
			swMeta_q <= {swHighPin, swMidPin, swLowPin};
			swSync_q <= swMeta_q;
			swPrev_q <= swSync_q;
		end
	end

	// --------------------------------------------------------------
	// Recovery sequencer
	// --------------------------------------------------------------
	cmbc_rec_e state_q, state_d;
	logic [31:0] timer_q, timer_d; // Edit window counter
	logic [1:0] settle_q, settle_d; // Lets the synchroniser fill
	logic apply_q, apply_d;
	logic protoOk_q, protoOk_d;
	logic newBacnet_q, newBacnet_d;
	logic baudOk_q, baudOk_d;
	cmbc_baud_t newBaud_q, newBaud_d;
	logic targetBacnet; // Protocol the chosen baud must suit

	// Next-state and selection decode
	always_comb begin
		state_d = state_q;
		timer_d = timer_q;
		settle_d = settle_q;
		apply_d = 1'b0;
		protoOk_d = protoOk_q;
		newBacnet_d = newBacnet_q;
		baudOk_d = baudOk_q;
		newBaud_d = newBaud_q;
		targetBacnet = curBacnet;
		case (state_q)
			RC_BOOT: begin
				// Wait until the synchroniser holds real pin values
				if (settle_q == `CMBC_SETTLE_CYCLES) begin
					if (swSync_q == {3{`CMBC_DIGIT_RECOVER}}) begin
						state_d = RC_EDIT;
					end else begin
						state_d = RC_DONE;
					end
				end else begin
					settle_d = settle_q + 2'h1;
				end
			end
			RC_EDIT: begin
				if (swSync_q != swPrev_q) begin
					timer_d = 32'h0000_0000;
				end else if (timer_q >= EDIT_CYCLES - 32'h0000_0001) begin
					// Quiet for the whole window: selections take effect
					state_d = RC_DONE;
					apply_d = 1'b1;
					protoOk_d = 1'b0;
					baudOk_d = 1'b0;
					// Low digit picks protocol
					if (swSync_q[3:0] == `CMBC_DIGIT_MODBUS) begin
						protoOk_d = 1'b1;
						newBacnet_d = 1'b0;
						targetBacnet = 1'b0;
					end else if (swSync_q[3:0] == `CMBC_DIGIT_BACNET) begin
						protoOk_d = 1'b1;
						newBacnet_d = 1'b1;
						targetBacnet = 1'b1;
					end
					// High digit picks baud; others keep old setting
					if (baudLegal(swSync_q[11:8], targetBacnet)) begin
						baudOk_d = 1'b1;
						newBaud_d = swSync_q[10:8];
					end
				end else begin
					timer_d = timer_q + 32'h0000_0001;
				end
			end
			RC_DONE: begin
				state_d = RC_DONE;
			end
			default: begin
				state_d = RC_BOOT;
			end
		endcase
	end

	// Register the sequencer
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_q <= RC_BOOT;
			timer_q <= 32'h0000_0000;
			settle_q <= 2'h0;
			apply_q <= 1'b0;
			protoOk_q <= 1'b0;
			newBacnet_q <= 1'b0;
			baudOk_q <= 1'b0;
			newBaud_q <= `CMBC_BAUD_9600;
		end else begin
			state_q <= state_d;
			timer_q <= timer_d;
			settle_q <= settle_d;
			apply_q <= apply_d;
			protoOk_q <= protoOk_d;
			newBacnet_q <= newBacnet_d;
			baudOk_q <= baudOk_d;
			newBaud_q <= newBaud_d;
		end
	end

	// Baud digit legal for the protocol it will run under
	function automatic logic baudLegal(input logic [3:0] dig,
		input logic bac);
		logic ok;
		ok = (dig >= 4'(`CMBC_BAUD_9600)) && (dig <= 4'(`CMBC_BAUD_115200));
		if (bac && ((dig == 4'(`CMBC_BAUD_57600)) ||
			(dig == 4'(`CMBC_BAUD_115200)))) begin
			ok = 1'b0;
		end
		return ok;
	endfunction : baudLegal

	// --------------------------------------------------------------
	// Outputs
	// --------------------------------------------------------------
	assign recoveryActive = (state_q == RC_EDIT);
	assign applyPulse = apply_q;
	assign protoOk = protoOk_q;
	assign newBacnet = newBacnet_q;
	assign baudOk = baudOk_q;
	assign newBaud = newBaud_q;
	// All-zero switches only count once the boot check is over
	assign failsafe = (state_q == RC_DONE) && (swSync_q == 12'h000);
	assign switchAddr = swSync_q;

endmodule : cmbc_switch_recovery

/* tb/cmbc_host_model.sv */
// Host model: register reads and writes on the block's register port.
// Assumes strobes are taken on the rising clk_sys edge, answer one later.
`timescale 1ns/1ps

module cmbc_host_model (
	input logic clk_sys,
	output logic [15:0] regAddr,
	output logic [15:0] regWrData,
	output logic regWrEn,
	output logic regRdEn,
	input logic [15:0] regRdData,
	input logic regRdValid
);
	// ------------------------------------------------
	// Idle bus at time zero
	// ------------------------------------------------
	initial begin
		regAddr = 16'h0000;
		regWrData = 16'h0000;
		regWrEn = 1'b0;
		regRdEn = 1'b0;
	end

	// One write; released lines show inverted values, not stale ones
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		regAddr <= a;
		regWrData <= d;
		regWrEn <= 1'b1;
		@(posedge clk_sys);
		regWrEn <= 1'b0;
		regAddr <= ~a;
		regWrData <= ~d;
		#1;
	endtask : wr

	// One read; unknown returned when no valid pulse came
	task automatic rd(input logic [15:0] a, output logic [15:0] d);
		@(posedge clk_sys);
		regAddr <= a;
		regRdEn <= 1'b1;
		@(posedge clk_sys);
		regRdEn <= 1'b0;
		regAddr <= ~a;
		#1;
		d = (regRdValid === 1'b1) ? regRdData : 16'hxxxx;
	endtask : rd

	// Wide quantity from a word pair, before scaling
	function automatic logic [31:0] combine(input logic [15:0] hi, lo);
		return hi * 32'h0001_0000 + lo;
	endfunction : combine
endmodule : cmbc_host_model

/* tb/cmbc_comm_config_sva.sv */
// Checker on the comm config top ports.
// Assumes one clk_sys domain with synchronous active-high rst.
`timescale 1ns/1ps
`include "cmbc_map.svh"

module cmbc_comm_config_sva
	import cmbc_pkg::*;
#(
	parameter logic [31:0] EDIT_CYCLES = 32'h0000_0032,
	parameter logic [31:0] FLASH_CYCLES = 32'h0000_0014
) (
	input logic clk_sys,
	input logic rst,
	input logic [15:0] regAddr,
	input logic [15:0] regWrData,
	input logic regWrEn,
	input logic regRdEn,
	input logic [15:0] regRdData,
	input logic regRdValid,
	input logic [31:0] energyTotal,
	input logic hostConnecting,
	input logic bacnetMode,
	input cmbc_baud_t baudCode,
	input logic [3:0] dataBits,
	input logic parityEnable,
	input logic [1:0] stopBits,
	input logic [11:0] switchAddr,
	input logic addrValid,
	input logic commLedGreen,
	input logic [2:0] phaseLedGreen
);
	// ------------------------------------------------
	// Helper state
	// ------------------------------------------------
	logic [31:0] snap_q, snap_d; // Energy at last low-word read
	logic [31:0] lowCnt_q, lowCnt_d; // Dark green LED run length

	// Next helper values
	always_comb begin
		snap_d = snap_q;
		lowCnt_d = 32'h0000_0000;
		if (regRdEn && regAddr == `CMBC_REG_ENERGY_LO) begin
			snap_d = energyTotal;
		end
		// Recovery display may darken the LED, so not counted
		if (!commLedGreen && addrValid) begin
			lowCnt_d = lowCnt_q + 32'h0000_0001;
		end
	end

	// Helper registers
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			snap_q <= 32'h0000_0000;
			lowCnt_q <= 32'h0000_0000;
		end else begin
			snap_q <= snap_d;
			lowCnt_q <= lowCnt_d;
		end
	end

	// ------------------------------------------------
	// Properties
	// ------------------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	a_energy_low: assert property (
		regRdEn && regAddr == `CMBC_REG_ENERGY_LO |=>
		regRdValid && regRdData == snap_q[15:0])
		else $error("low energy word wrong");
	a_energy_snap: assert property (
		regRdEn && regAddr == `CMBC_REG_ENERGY_HI |=>
		regRdValid && regRdData == snap_q[31:16])
		else $error("high energy word not from snapshot");
	a_bacnet_key: assert property (
		(regWrEn && regAddr == `CMBC_REG_PROTO && !bacnetMode && addrValid
		&& regWrData == `CMBC_KEY_TO_BACNET && switchAddr != 12'h000)
		##1 (switchAddr != 12'h000) |-> bacnetMode && baudCode == 3'h5)
		else $error("bacnet key not applied");
	a_modbus_key: assert property (
		regWrEn && regAddr == `CMBC_OBJ_PROTO && bacnetMode && addrValid
		&& regWrData == `CMBC_KEY_TO_MODBUS |=>
		!bacnetMode && baudCode == 3'h1)
		else $error("modbus key not applied");
	a_baud_legal: assert property (
		baudCode inside {[3'h1:3'h6]} &&
		!(bacnetMode && (baudCode == 3'h4 || baudCode == 3'h6)))
		else $error("illegal baud for protocol");
	a_frame_fixed: assert property (
		dataBits == 4'h8 && !parityEnable && stopBits == 2'h1)
		else $error("serial frame not 8N1");
	a_failsafe_force: assert property (
		(switchAddr == 12'h000)[*3] |-> !bacnetMode && baudCode == 3'h1)
		else $error("failsafe not forcing modbus 9600");
	a_rec_phase: assert property (
		(!addrValid && $stable(switchAddr) &&
		switchAddr[11:8] inside {[4'h1:4'h6]})[*2] |->
		phaseLedGreen == switchAddr[10:8])
		else $error("phase LEDs do not show baud digit");
	a_connect_start: assert property (
		hostConnecting && commLedGreen && $past(commLedGreen) && addrValid
		|=> !commLedGreen)
		else $error("connect flash did not start");
	a_flash_bound: assert property (
		lowCnt_q <= FLASH_CYCLES + FLASH_CYCLES + 32'h0000_0004)
		else $error("status LED not back to solid green");
endmodule : cmbc_comm_config_sva

bind cmbc_comm_config cmbc_comm_config_sva #(
	.EDIT_CYCLES(EDIT_CYCLES),
	.FLASH_CYCLES(FLASH_CYCLES)
) u_sva (.clk_sys, .rst, .regAddr, .regWrData, .regWrEn, .regRdEn,
	.regRdData, .regRdValid, .energyTotal, .hostConnecting, .bacnetMode,
	.baudCode, .dataBits, .parityEnable, .stopBits, .switchAddr,
	.addrValid, .commLedGreen, .phaseLedGreen);

/* tb/cmbc_comm_config_tb.sv */
// Self-checking bench for the comm config block top.
// Assumes the host model and checker files compile before this one.
`timescale 1ns/1ps
`include "cmbc_map.svh"

module cmbc_comm_config_tb;
	import cmbc_pkg::*;
	// ------------------------------------------------
	// Shortened counts keep the run brief
	// ------------------------------------------------
	localparam int EDIT_N = 50;
	localparam int FLASH_N = 20;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [3:0] swHighPin = 4'h1, swMidPin = 4'h2, swLowPin = 4'h3;
	logic [15:0] regAddr, regWrData, regRdData;
	logic regWrEn, regRdEn, regRdValid;
	logic [31:0] energyTotal = 32'h0000_0000;
	logic hostConnecting = 1'b0, hostFailed = 1'b0;
	logic bacnetMode, parityEnable, addrValid;
	logic serialLedRed, commLedRed, commLedGreen;
	cmbc_baud_t baudCode;
	logic [3:0] dataBits;
	logic [1:0] stopBits;
	logic [2:0] scalarCode, phaseLedGreen;
	logic [11:0] switchAddr;
	int n_fail = 0, cmp_count = 0;
	logic [15:0] lfsrState = 16'h14f4; // Fixed seed
	logic [15:0] rdv, lo, hi, v;
	logic [31:0] e, w;
	logic expB;
	cmbc_baud_t expC;
	// Recovery cases: protocol digit and baud digit
	logic [3:0] recLow [4] = '{4'h2, 4'h1, 4'h3, 4'h2};
	logic [3:0] recHigh [4] = '{4'h5, 4'h4, 4'h7, 4'h4};

	always #10 clk_sys = ~clk_sys; // 50 MHz

	cmbc_comm_config #(.EDIT_CYCLES(32'(EDIT_N)),
		.FLASH_CYCLES(32'(FLASH_N))) dut (.clk_sys, .rst, .swHighPin,
		.swMidPin, .swLowPin, .regAddr, .regWrData, .regWrEn, .regRdEn,
		.regRdData, .regRdValid, .energyTotal, .hostConnecting,
		.hostFailed, .bacnetMode, .baudCode, .dataBits, .parityEnable,
		.stopBits, .scalarCode, .switchAddr, .addrValid, .serialLedRed,
		.commLedRed, .commLedGreen, .phaseLedGreen);

	cmbc_host_model host (.clk_sys, .regAddr, .regWrData, .regWrEn,
		.regRdEn, .regRdData, .regRdValid);

	// ------------------------------------------------
	// Bench helpers
	// ------------------------------------------------
	function automatic logic [15:0] lfsr16();
		lfsrState = {lfsrState[14:0],
			lfsrState[15] ^ lfsrState[13] ^ lfsrState[12] ^ lfsrState[10]};
		return lfsrState;
	endfunction : lfsr16

	// Baud code allowed for a protocol
	function automatic logic baudOk(input logic b, input logic [2:0] c);
		return c >= 3'h1 && c <= 3'h6 && !(b && (c == 3'h4 || c == 3'h6));
	endfunction : baudOk

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic chkBit(input logic got, input logic exp);
		chk({15'h0000, got}, {15'h0000, exp});
	endtask : chkBit

	task automatic chkCfg(input logic b, input cmbc_baud_t c);
		chk({12'h000, bacnetMode, baudCode}, {12'h000, b, c});
	endtask : chkCfg

	// Settle just past an edge
	task automatic waitClk(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : waitClk

	task automatic doReset(input logic [3:0] h, m, l);
		@(posedge clk_sys);
		rst <= 1'b1;
		swHighPin <= h;
		swMidPin <= m;
		swLowPin <= l;
		repeat (20) @(posedge clk_sys);
		rst <= 1'b0;
		waitClk(6);
	endtask : doReset

	task automatic conclude();
		$display("checks %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : conclude

	// Hang guard
	initial begin
		repeat (20000) @(posedge clk_sys);
		n_fail++;
		conclude();
	end

	// ------------------------------------------------
	// Main sequence
	// ------------------------------------------------
	initial begin
		doReset(4'h1, 4'h2, 4'h3);
		chkCfg(1'b0, 3'h1);
		chk({9'h000, dataBits, parityEnable, stopBits}, 16'h0041);
		chkBit(addrValid, 1'b1);
		chkBit(commLedGreen, 1'b1);
		// High word before any low read: reset snapshot
		host.rd(`CMBC_REG_ENERGY_HI, rdv);
		chk(rdv, 16'h0000);
		for (int n = 0; n < 5; n++) begin
			e = (n == 0) ? 32'h000d_1395 : {lfsr16(), lfsr16()};
			@(posedge clk_sys);
			energyTotal <= e;
			host.rd(`CMBC_REG_ENERGY_LO, lo);
			@(posedge clk_sys);
			energyTotal <= ~e;
			host.wr(`CMBC_REG_ENERGY_HI, lfsr16());
			host.rd(`CMBC_REG_ENERGY_HI, hi);
			w = host.combine(hi, lo);
			chk(w[15:0], e[15:0]);
			chk(w[31:16], e[31:16]);
		end
		host.rd(16'h1234, rdv);
		chk(rdv, 16'h0000);
		// Protocol keys, right and wrong place
		host.wr(`CMBC_REG_PROTO, `CMBC_KEY_TO_MODBUS);
		chkCfg(1'b0, 3'h1);
		host.wr(`CMBC_REG_PROTO, `CMBC_KEY_TO_BACNET);
		chkCfg(1'b1, 3'h5);
		host.rd(`CMBC_REG_PROTO, rdv);
		chk(rdv, 16'h0001);
		host.wr(`CMBC_OBJ_PROTO, `CMBC_KEY_TO_BACNET);
		host.wr(`CMBC_REG_PROTO, `CMBC_KEY_TO_MODBUS);
		chkCfg(1'b1, 3'h5);
		host.wr(`CMBC_OBJ_PROTO, `CMBC_KEY_TO_MODBUS);
		chkCfg(1'b0, 3'h1);
		// Every baud code in both protocols
		for (int m = 0; m < 2; m++) begin
			if (m == 1) begin
				host.wr(`CMBC_REG_PROTO, `CMBC_KEY_TO_BACNET);
			end
			expC = (m == 1) ? 3'h5 : 3'h1;
			for (int c = 0; c < 8; c++) begin
				host.wr(`CMBC_REG_BAUD, c[15:0]);
				if (baudOk(m[0], c[2:0])) begin
					expC = c[2:0];
				end
				chkCfg(m[0], expC);
			end
		end
		// Data scalar, saturating, plus one random value
		for (int i = 0; i < 9; i++) begin
			v = (i == 8) ? lfsr16() : i[15:0];
			host.wr(`CMBC_REG_SCALAR, v);
			host.rd(`CMBC_REG_SCALAR, rdv);
			chk(rdv, (v > 16'h0006) ? 16'h0006 : v);
			chk({13'h0000, scalarCode}, (v > 16'h0006) ? 16'h0006 : v);
		end
		// Failsafe masks while stores stay writable
		@(posedge clk_sys);
		{swHighPin, swMidPin, swLowPin} <= 12'h000;
		waitClk(6);
		chkCfg(1'b0, 3'h1);
		host.wr(`CMBC_REG_BAUD, 16'h0003);
		host.rd(`CMBC_REG_BAUD, rdv);
		chk(rdv, 16'h0003);
		@(posedge clk_sys);
		{swHighPin, swMidPin, swLowPin} <= 12'h123;
		waitClk(6);
		chkCfg(1'b1, 3'h3);
		// Connect then failure flash
		for (int j = 0; j < 2; j++) begin
			@(posedge clk_sys);
			{hostFailed, hostConnecting} <= (j == 1) ? 2'b10 : 2'b01;
			@(posedge clk_sys);
			{hostFailed, hostConnecting} <= 2'b00;
			#1;
			chkBit(commLedGreen, 1'b0);
			chkBit(commLedRed, j == 1);
			waitClk(FLASH_N + 4);
			chkBit(commLedGreen, 1'b1);
			chkBit(commLedRed, 1'b0);
		end
		// Switch recovery, window kept open by steps
		for (int i = 0; i < 4; i++) begin
			doReset(4'h9, 4'h9, 4'h9);
			chkBit(addrValid, 1'b0);
			@(posedge clk_sys);
			swLowPin <= recLow[i];
			for (int k = 1; k <= 6; k++) begin
				@(posedge clk_sys);
				swHighPin <= k[3:0];
				waitClk(10);
				chk({13'h0000, phaseLedGreen}, k[15:0]);
			end
			chkBit(addrValid, 1'b0);
			if (recLow[i] != 4'h3) begin
				chkBit(serialLedRed, 1'b1);
				chkBit(commLedRed, recLow[i] == 4'h2);
			end
			@(posedge clk_sys);
			swHighPin <= recHigh[i];
			waitClk(40);
			chkBit(addrValid, 1'b0);
			waitClk(25);
			expB = (recLow[i] == 4'h2);
			expC = baudOk(expB, recHigh[i][2:0]) ? recHigh[i][2:0] : 3'h1;
			chkCfg(expB, expC);
			chkBit(addrValid, 1'b1);
			chk({4'h0, switchAddr}, {4'h0, recHigh[i], 4'h9, recLow[i]});
		end
		conclude();
	end
endmodule : cmbc_comm_config_tb
